// >>> hw/mih_pkg.sv
// Package for the multiprocessor interrupt hub: register map, source
// numbering, field positions, reset values and the acknowledge carrier.
// Assumes a 32-bit APB register bus and a 3-bit processor priority level.
package mih_pkg;

    // Source count and source numbering
    localparam int NSRC         = 40;
    localparam int SRC_SERIAL   = 0;   // serial_comm_controller
    localparam int SRC_CLOCK    = 1;   // Clock chip
    localparam int SRC_TIMER    = 2;   // Two timers, 2..3
    localparam int SRC_VME      = 4;   // VMEbus lines 1..7 at 4..10
    localparam int SRC_VMX      = 11;  // Secondary bus line
    localparam int SRC_ACFAIL   = 12;  // Power-fail
    localparam int SRC_SYSFAIL  = 13;  // System failure
    localparam int SRC_MBOX     = 14;  // Mailboxes 14..21
    localparam int SRC_BQ0      = 22;  // broadcast_queue_zero
    localparam int SRC_BS1      = 23;  // broadcast_slot_one
    localparam int SRC_INT      = 24;  // Internal sources 24..39
    localparam int NINT         = 16;
    localparam int NMBOX        = 8;

    // Sources whose vector is fetched instead of driven by the hub
    localparam logic [39:0] FETCH_MASK = 40'h0000000FF1;

    // Vector offsets added to the base vector
    localparam logic [7:0] MBOX_VEC_OFS = 8'h28;  // Plus the level
    localparam logic [7:0] SPUR_VEC_OFS = 8'h30;  // No source pending

    // Register byte addresses
    localparam logic [7:0] A_CTRL  = 8'h00;  // Base vector, board slot
    localparam logic [7:0] A_LVL0  = 8'h10;  // Five level registers
    localparam logic [7:0] A_PENDL = 8'h24;  // Pending 0..31
    localparam logic [7:0] A_PENDH = 8'h28;  // Pending 32..39
    localparam logic [7:0] A_MBOX  = 8'h2C;  // Mailbox flags, W1C
    localparam logic [7:0] A_BQ0   = 8'h30;  // Queue read, pops
    localparam logic [7:0] A_BS1   = 8'h34;  // Slot read, pops
    localparam logic [7:0] A_EVT   = 8'h38;  // Event status, read clears
    localparam logic [7:0] A_MASK  = 8'h3C;  // Event mask
    localparam logic [7:0] A_IPL   = 8'h40;  // Current level

    // Field positions
    localparam int F_BASE   = 0;   // CTRL[7:0]
    localparam int F_SLOT   = 8;   // CTRL[12:8]
    localparam int F_VALID  = 8;   // Data read: message valid
    localparam int F_COUNT  = 9;   // Data read: entries before pop
    localparam int LVL_PER  = 8;   // Sources per level register
    localparam int NEVT     = 4;
    localparam int E_OVF0   = 0;   // Queue overflow
    localparam int E_OVF1   = 1;   // Slot overflow
    localparam int E_MBOX   = 2;   // Mailbox touched
    localparam int E_SPUR   = 3;   // Acknowledge with nothing pending

    // Reset values
    localparam logic [7:0] RST_BASE = 8'h40;
    localparam logic [4:0] RST_SLOT = 5'h00;
    localparam logic [2:0] RST_LVL  = 3'h0;   // Level 0: source off

    // Acknowledge answer carrier
    typedef struct packed {
        logic [7:0] vector;  // Vector driven by the hub
        logic       fetch;   // Vector must be fetched from the source
        logic [5:0] src;     // Winning source
    } mih_iack_t;

endpackage : mih_pkg

// >>> hw/mih_top.sv
// Multiprocessor interrupt hub: merges forty sources into one processor
// level, answers acknowledges, runs mailboxes and broadcast receivers.
// Assumes one clock, synchronous inputs and an APB master for software.
//
// Design decisions made here: the APB register port and the register offsets.
`timescale 1ns/10ps

// Overview of operation
// - Each source has its own level 1..7
// - Local, timer, internal, VMEbus, secondary lines merged
// - Acknowledge drives vector or requests a fetch
// - Power-fail and system-failure are level-programmable sources
// - Forty sources, each with level and vector
// - Vector of a non-mailbox source is base plus fixed source offset
// - Eight mailboxes; remote access raises interrupt
// - Mailbox level programmable, vector per level
// - Remote mailbox access is atomic test-and-set
// - Addressed board captures message, raises interrupt
// - Channel zero queues eight byte messages
// - Channel one holds one urgent byte
module mih_top #(
    parameter int BQ_DEPTH = 8,    // Queue entries
    parameter int NBOARD   = 20    // Boards a broadcast can address
) (
    // Clock and reset
    input  wire logic                   mclk,
    input  wire logic                   reset_n,
    // APB slave
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [7:0]             paddr,
    input  wire logic [31:0]            pwdata,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,
    // Interrupt request lines, active high levels
    input  wire logic                   serial_irq,
    input  wire logic                   clock_irq,
    input  wire logic [1:0]             timer_irq,
    input  wire logic [6:0]             vme_irq,
    input  wire logic                   vmx_irq,
    input  wire logic                   acfail,
    input  wire logic                   sysfail,
    input  wire logic [15:0]            internal_irq,
    // Processor level and acknowledge
    output logic      [2:0]             cpu_ipl,
    input  wire logic                   cpu_iack,
    input  wire logic [2:0]             cpu_iack_lvl,
    output logic                        iack_done,
    output mih_pkg::mih_iack_t          iack_ans,
    // Remote mailbox access, one indivisible cycle
    input  wire logic                   mbx_stb,
    input  wire logic [2:0]             mbx_idx,
    output logic                        mbx_ack,
    output logic                        mbx_old,
    // Broadcast write from the bus
    input  wire logic                   bcast_wr,
    input  wire logic                   bcast_chan,
    input  wire logic [NBOARD-1:0]      bcast_boards,
    input  wire logic [7:0]             bcast_data,
    // Event interrupt
    output logic                        irq
);
    import mih_pkg::*;

    localparam int CW = $clog2(BQ_DEPTH);

    // Configuration and state
    logic [7:0]          base_r;              // Base vector
    logic [4:0]          slot_r;              // This board's slot
    logic [2:0]          lvl_r [NSRC];        // Per-source level
    logic [NMBOX-1:0]    mbox_r;              // Mailbox flags
    logic [7:0]          bq_mem [BQ_DEPTH];   // Queue storage
    logic [CW-1:0]       bq_wp_r, bq_rp_r;    // Queue pointers
    logic [CW:0]         bq_cnt_r;            // Queue fill
    logic [7:0]          bs_data_r;           // Slot message
    logic                bs_full_r;           // Slot holds a message
    logic [NEVT-1:0]     evt_r, mask_r;       // Event status and mask
    logic [31:0]         prdata_r;
    logic                pready_r, pslverr_r;
    logic [2:0]          ipl_r;
    logic                iack_done_r;
    mih_iack_t           iack_r;
    logic                mbx_ack_r, mbx_old_r;
    logic                irq_r;

    // Pending vector, all sources
    logic [NSRC-1:0]     pend;

    assign pend = {internal_irq,
                   bs_full_r, (bq_cnt_r != '0),
                   mbox_r,
                   sysfail, acfail,
                   vmx_irq, vme_irq, timer_irq,
                   clock_irq, serial_irq};

    // Lowest-numbered pending source at a level wins
    function automatic logic [6:0] pick(input logic [NSRC-1:0] p,
                                        input logic [2:0] lv);
        logic [6:0] r;
        r = 7'h00;
        for (int i = NSRC - 1; i >= 0; i--) begin
            if (p[i] && lvl_r[i] == lv && lv != 3'h0) begin
                r = {1'b1, 6'(i)};
            end
        end
        return r;
    endfunction : pick

    // Highest active level among pending sources
    logic [2:0] ipl_nxt;
    always_comb begin
        ipl_nxt = 3'h0;
        for (int i = 0; i < NSRC; i++) begin
            if (pend[i] && lvl_r[i] > ipl_nxt) begin
                ipl_nxt = lvl_r[i];
            end
        end
    end

    // Acknowledge decode; a process, so a level write re-runs the pick
    logic [6:0] win;
    always_comb win = pick(pend, cpu_iack_lvl);
    wire        win_ok  = win[6];
    wire  [5:0] win_src = win[5:0];
    wire        win_mbx = win_ok && win_src >= 6'(SRC_MBOX)
                          && win_src < 6'(SRC_MBOX + NMBOX);
    wire  [7:0] vec_nxt = !win_ok ? base_r + SPUR_VEC_OFS
                        : win_mbx ? base_r + MBOX_VEC_OFS
                                    + {5'h00, cpu_iack_lvl}
                        : base_r + {2'h0, win_src};
    wire        fet_nxt = win_ok && FETCH_MASK[win_src];

    // APB decode; the completing edge is the one that sees pready high
    wire        apb_acc  = psel && penable;
    wire        apb_done = apb_acc && pready_r;
    wire        apb_wr   = apb_done && pwrite;
    wire        a_lvl    = paddr >= A_LVL0 && paddr < A_PENDL
                           && paddr[1:0] == 2'h0;
    wire  [2:0] lvl_sel  = 3'((paddr - A_LVL0) >> 2);
    wire        a_known  = paddr == A_CTRL || a_lvl || paddr == A_PENDL
                           || paddr == A_PENDH || paddr == A_MBOX
                           || paddr == A_BQ0 || paddr == A_BS1
                           || paddr == A_EVT || paddr == A_MASK
                           || paddr == A_IPL;

    // Read mux
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (paddr)
            A_CTRL:  rd_mux = {19'h0, slot_r, base_r};
            A_PENDL: rd_mux = pend[31:0];
            A_PENDH: rd_mux = {24'h0, pend[NSRC-1:32]};
            A_MBOX:  rd_mux = {24'h0, mbox_r};
            A_BQ0:   rd_mux = {19'h0, 4'(bq_cnt_r),
                               bq_cnt_r != '0, bq_mem[bq_rp_r]};
            A_BS1:   rd_mux = {23'h0, bs_full_r, bs_data_r};
            A_EVT:   rd_mux = {28'h0, evt_r};
            A_MASK:  rd_mux = {28'h0, mask_r};
            A_IPL:   rd_mux = {29'h0, ipl_r};
            default: begin
                if (a_lvl) begin
                    for (int j = 0; j < LVL_PER; j++) begin
                        if (int'(lvl_sel) * LVL_PER + j < NSRC) begin
                            rd_mux[4*j +: 3] =
                                lvl_r[int'(lvl_sel) * LVL_PER + j];
                        end
                    end
                end
            end
        endcase
    end

    // Pops and read-clears act only on what the latched read showed,
    // so a message or event arriving during the access is never lost
    wire pop_bq  = apb_done && !pwrite && paddr == A_BQ0
                   && prdata_r[F_VALID];
    wire pop_bs  = apb_done && !pwrite && paddr == A_BS1
                   && prdata_r[F_VALID];
    wire evt_rdc = apb_done && !pwrite && paddr == A_EVT;

    // Broadcast accept for this board
    // A slot beyond the board count never matches, so no unknown select
    wire bc_hit  = bcast_wr && 32'(slot_r) < NBOARD
                   && bcast_boards[slot_r];
    wire bq_push = bc_hit && !bcast_chan;
    wire bs_push = bc_hit && bcast_chan;
    wire bq_ovf  = bq_push && bq_cnt_r == (CW+1)'(BQ_DEPTH);
    wire bs_ovf  = bs_push && bs_full_r && !pop_bs;

    // Event sets; a set in the clearing cycle wins
    wire [NEVT-1:0] evt_set = {cpu_iack && !win_ok,
                               mbx_stb, bs_ovf, bq_ovf};
    wire [NEVT-1:0] evt_nxt = (evt_r & ~(evt_rdc ? prdata_r[NEVT-1:0]
                                                 : '0)) | evt_set;

    // APB answer: one wait state, data and error from flops
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0000_0000;
        end else begin
            pready_r  <= apb_acc && !pready_r;
            pslverr_r <= apb_acc && !pready_r && !a_known;
            if (apb_acc && !pready_r) begin
                prdata_r <= a_known ? rd_mux : 32'h0000_0000;
            end
        end
    end

    // Control registers and per-source levels
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            base_r <= RST_BASE;
            slot_r <= RST_SLOT;
            mask_r <= '0;
            for (int i = 0; i < NSRC; i++) begin
                lvl_r[i] <= RST_LVL;
            end
        end else if (apb_wr) begin
            if (paddr == A_CTRL) begin
                base_r <= pwdata[F_BASE +: 8];
                slot_r <= pwdata[F_SLOT +: 5];
            end
            if (paddr == A_MASK) begin
                mask_r <= pwdata[NEVT-1:0];
            end
            if (a_lvl) begin
                for (int j = 0; j < LVL_PER; j++) begin
                    if (int'(lvl_sel) * LVL_PER + j < NSRC) begin
                        lvl_r[int'(lvl_sel) * LVL_PER + j] <=
                            pwdata[4*j +: 3];
                    end
                end
            end
        end
    end

    // Mailboxes: remote test-and-set in a single cycle, software clear
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            mbox_r    <= '0;
            mbx_ack_r <= 1'b0;
            mbx_old_r <= 1'b0;
        end else begin
            mbx_ack_r <= mbx_stb;
            if (mbx_stb) begin
                mbx_old_r <= mbox_r[mbx_idx];
            end
            for (int k = 0; k < NMBOX; k++) begin
                if (mbx_stb && mbx_idx == 3'(k)) begin
                    mbox_r[k] <= 1'b1;
                end else if (apb_wr && paddr == A_MBOX
                             && pwdata[k]) begin
                    mbox_r[k] <= 1'b0;
                end
            end
        end
    end

    // Queue storage has no reset; only pointers matter
    always_ff @(posedge mclk) begin
        if (bq_push && !bq_ovf) begin
            bq_mem[bq_wp_r] <= bcast_data;
        end
    end

    // Queue pointers and slot one
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            bq_wp_r   <= '0;
            bq_rp_r   <= '0;
            bq_cnt_r  <= '0;
            bs_full_r <= 1'b0;
            bs_data_r <= 8'h00;
        end else begin
            if (bq_push && !bq_ovf) begin
                bq_wp_r <= CW'((bq_wp_r + 1'b1) % BQ_DEPTH);
            end
            if (pop_bq) begin
                bq_rp_r <= CW'((bq_rp_r + 1'b1) % BQ_DEPTH);
            end
            bq_cnt_r <= bq_cnt_r + (CW+1)'(bq_push && !bq_ovf)
                        - (CW+1)'(pop_bq);
            // Slot one: a pop and a new message may meet in one cycle
            if (bs_push && (!bs_full_r || pop_bs)) begin
                bs_data_r <= bcast_data;
                bs_full_r <= 1'b1;
            end else if (pop_bs) begin
                bs_full_r <= 1'b0;
            end
        end
    end

    // Level output, acknowledge answer, events and interrupt line
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            ipl_r       <= 3'h0;
            iack_done_r <= 1'b0;
            iack_r      <= '0;
            evt_r       <= '0;
            irq_r       <= 1'b0;
        end else begin
            ipl_r       <= ipl_nxt;
            iack_done_r <= cpu_iack;
            if (cpu_iack) begin
                iack_r <= '{vector: vec_nxt, fetch: fet_nxt,
                            src: win_src};
            end
            evt_r <= evt_nxt;
            irq_r <= |(evt_nxt & mask_r);
        end
    end

    // Outputs straight from flops
    assign prdata    = prdata_r;
    assign pready    = pready_r;
    assign pslverr   = pslverr_r;
    assign cpu_ipl   = ipl_r;
    assign iack_done = iack_done_r;
    assign iack_ans  = iack_r;
    assign mbx_ack   = mbx_ack_r;
    assign mbx_old   = mbx_old_r;
    assign irq       = irq_r;

endmodule : mih_top

// >>> testbench/mih_props.sv
// Checker for the interrupt hub: APB timing, acknowledge and mailbox.
// Assumes it is bound to mih_top and sees only that module's ports.
`timescale 1ns/10ps
module mih_props (
    // Clock and reset
    input wire logic               mclk,
    input wire logic               reset_n,
    // APB slave side
    input wire logic               psel,
    input wire logic               penable,
    input wire logic               pwrite,
    input wire logic [7:0]         paddr,
    input wire logic [31:0]        pwdata,
    input wire logic               pready,
    input wire logic               pslverr,
    // Acknowledge
    input wire logic               cpu_iack,
    input wire logic               iack_done,
    input wire mih_pkg::mih_iack_t iack_ans,
    // Mailbox cycle
    input wire logic               mbx_stb,
    input wire logic [2:0]         mbx_idx,
    input wire logic               mbx_ack,
    input wire logic               mbx_old
);
    import mih_pkg::*;
    logic [7:0] base_r;  // Shadow of the programmed base vector
    logic [7:0] mlvl;    // Level folded into a mailbox vector
    // Follow accepted writes only; a refused write must not move it
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            base_r <= RST_BASE;
        end else if (psel && penable && pready && pwrite && !pslverr
                     && paddr == A_CTRL) begin
            base_r <= pwdata[7:0];
        end
    end
    assign mlvl = iack_ans.vector - base_r - MBOX_VEC_OFS;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    chk_access_wait: assert property ($rose(penable) && psel
        |-> !pready ##1 pready) else $error("access not one wait state");
    chk_err_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    chk_ack_answer: assert property (cpu_iack |=> iack_done)
        else $error("acknowledge not answered");
    chk_ans_hold: assert property ($past(reset_n) && !iack_done
        |-> $stable(iack_ans)) else $error("answer moved between acks");
    chk_src_vector: assert property (iack_done && iack_ans.src > 6'd21
        |-> iack_ans.vector == base_r + {2'h0, iack_ans.src})
        else $error("vector not base plus source");
    chk_fetch_flag: assert property (iack_done
        && iack_ans.src inside {[4:13]}
        |-> iack_ans.fetch == (iack_ans.src <= 6'd11))
        else $error("fetch flag wrong for source");
    chk_mbox_vector: assert property (iack_done
        && iack_ans.src inside {[14:21]} |-> mlvl inside {[1:7]})
        else $error("mailbox vector off");
    chk_mbox_ack: assert property (mbx_stb |=> mbx_ack)
        else $error("mailbox cycle not answered");
    chk_mbox_atomic: assert property (mbx_stb && $past(mbx_stb)
        && mbx_idx == $past(mbx_idx) |=> mbx_old)
        else $error("second test-and-set saw a clear flag");
endmodule : mih_props

// >>> testbench/mih_remote.sv
// Remote bus master model: atomic mailbox cycles and broadcast writes.
// Assumes the hub samples each request at a rising edge of mclk.
`timescale 1ns/10ps
module mih_remote #(
    parameter int NBOARD = 20  // Boards a broadcast can address
) (
    // Clock
    input  wire logic         mclk,
    // Mailbox cycle
    output logic              mbx_stb,
    output logic [2:0]        mbx_idx,
    // Broadcast write
    output logic              bcast_wr,
    output logic              bcast_chan,
    output logic [NBOARD-1:0] bcast_boards,
    output logic [7:0]        bcast_data
);
    // Bus idle at time zero
    initial begin
        mbx_stb = 1'b0;
        mbx_idx = 3'h0;
        bcast_wr = 1'b0;
        bcast_chan = 1'b0;
        bcast_boards = '0;
        bcast_data = 8'h00;
    end
    // n indivisible test-and-set cycles back to back on one box
    task automatic mbox(input logic [2:0] idx, input int n);
        @(posedge mclk);
        mbx_stb <= 1'b1;
        mbx_idx <= idx;
        repeat (n) @(posedge mclk);
        mbx_stb <= 1'b0;
        mbx_idx <= ~idx;  // Released lines never keep a stale index
    endtask : mbox
    // One write cycle reaches every selected board at once
    task automatic bcast(input logic ch, input logic [NBOARD-1:0] bd,
                         input logic [7:0] d);
        @(posedge mclk);
        bcast_wr <= 1'b1;
        bcast_chan <= ch;
        // Board mask stands for the decode of a 32-bit address
        bcast_boards <= bd;
        bcast_data <= d;
        @(posedge mclk);
        bcast_wr <= 1'b0;
        bcast_chan <= ~ch;  // Inverted so stale data cannot pass
        bcast_boards <= ~bd;
        bcast_data <= ~d;
    endtask : bcast
endmodule : mih_remote

// >>> testbench/tb_multiprocessor_interrupt_hub.sv
// Testbench for the interrupt hub: APB and acknowledge tasks, checks.
// Assumes mih_top, mih_props and mih_remote are compiled before it.
`timescale 1ns/10ps
module tb_multiprocessor_interrupt_hub;
    import mih_pkg::*;
    logic        mclk, reset_n, psel, penable, pwrite;  // Clock, APB
    logic [7:0]  paddr, bcast_data;
    logic [31:0] pwdata, prdata, rd;  // rd: last read word
    logic        pready, pslverr, err;  // err: last error flag
    logic        serial_irq, clock_irq, vmx_irq, acfail, sysfail;
    logic [1:0]  timer_irq;
    logic [6:0]  vme_irq;
    logic [15:0] internal_irq;
    logic [2:0]  cpu_ipl, iack_lvl, mbx_idx;
    logic        cpu_iack, iack_done, mbx_stb, mbx_ack, mbx_old, irq;
    logic        bcast_wr, bcast_chan;
    logic [19:0] bcast_boards;
    mih_iack_t   iack_ans;
    int          mismatches, n_checks;
    mih_top i_dut (.mclk, .reset_n, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .serial_irq, .clock_irq,
        .timer_irq, .vme_irq, .vmx_irq, .acfail, .sysfail, .internal_irq,
        .cpu_ipl, .cpu_iack, .cpu_iack_lvl(iack_lvl), .iack_done,
        .iack_ans, .mbx_stb, .mbx_idx, .mbx_ack, .mbx_old, .bcast_wr,
        .bcast_chan, .bcast_boards, .bcast_data, .irq);
    mih_remote i_rem (.mclk, .mbx_stb, .mbx_idx, .bcast_wr, .bcast_chan,
        .bcast_boards, .bcast_data);
    // Free-running 125 MHz clock
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    task automatic chk_word(input logic [31:0] got, exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk_word
    task automatic chk_flag(input logic got, exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: flag %b want %b", $time, got, exp);
        end
    endtask : chk_flag
    // One APB transfer; only the watchdog ends the wait for pready
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        chk_word(n, 32'd2);
    endtask : apb
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, e);
        apb(1'b0, a, 32'h0);
        chk_word(rd & m, e);
    endtask : rd_chk
    // Acknowledge a level, compare the answer one cycle later
    task automatic ack(input logic [2:0] l, input logic [7:0] v,
                       input logic f, input logic [5:0] s);
        @(posedge mclk);
        cpu_iack <= 1'b1;
        iack_lvl <= l;
        @(posedge mclk);
        cpu_iack <= 1'b0;
        @(posedge mclk);
        chk_flag(iack_done, 1'b1);
        chk_word({17'h0, iack_ans}, {17'h0, v, f, s});
    endtask : ack
    task automatic ipl_is(input logic [2:0] l);
        repeat (3) @(posedge mclk);
        chk_word({29'h0, cpu_ipl}, {29'h0, l});
    endtask : ipl_is
    task automatic tally_and_finish;
        if (mismatches == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : tally_and_finish
    // Watchdog: the whole sequence needs well under 3000 cycles
    initial begin
        repeat (5000) @(posedge mclk);
        mismatches++;
        $display("Error at %0t: timeout", $time);
        tally_and_finish();
    end
    // Main sequence
    initial begin
        {reset_n, psel, penable, pwrite, paddr, pwdata} = '0;
        {serial_irq, clock_irq, timer_irq, vme_irq, vmx_irq} = '0;
        {acfail, sysfail, internal_irq, cpu_iack, iack_lvl} = '0;
        mismatches = 0;
        n_checks = 0;
        repeat (8) @(posedge mclk);
        reset_n <= 1'b1;
        rd_chk(A_CTRL, 32'hFFFFFFFF, 32'h40);
        rd_chk(8'hFC, 32'hFFFFFFFF, 32'h0);
        chk_flag(err, 1'b1);
        apb(1'b1, A_CTRL, 32'h80);
        apb(1'b1, A_MASK, 32'hF);
        apb(1'b1, A_LVL0, 32'h32);
        apb(1'b1, A_LVL0 + 8'h4, 32'h04550700);
        apb(1'b1, A_LVL0 + 8'h8, 32'h62000000);
        apb(1'b1, A_LVL0 + 8'hC, 32'h1);
        serial_irq <= 1'b1;
        clock_irq <= 1'b1;
        ipl_is(3'd3);
        ack(3'd3, 8'h81, 1'b0, 6'd1);
        ack(3'd2, 8'h80, 1'b1, 6'd0);
        {serial_irq, clock_irq} <= 2'b00;
        {acfail, sysfail, vmx_irq, timer_irq} <= 5'h1F;
        vme_irq <= 7'h40;
        ipl_is(3'd7);
        ack(3'd7, 8'h8A, 1'b1, 6'd10);
        ack(3'd5, 8'h8C, 1'b0, 6'd12);
        acfail <= 1'b0;
        vme_irq <= 7'h00;
        ipl_is(3'd5);
        ack(3'd5, 8'h8D, 1'b0, 6'd13);
        {sysfail, vmx_irq, timer_irq} <= 4'h0;
        internal_irq <= 16'h0001;
        ack(3'd1, 8'h98, 1'b0, 6'd24);
        internal_irq <= 16'h0000;
        ack(3'd6, 8'hB0, 1'b0, 6'd0);
        i_rem.mbox(3'd0, 2);
        chk_flag(mbx_old, 1'b0);
        ipl_is(3'd4);
        chk_flag(mbx_old, 1'b1);
        ack(3'd4, 8'hAC, 1'b0, 6'd14);
        rd_chk(A_MBOX, 32'hFF, 32'h1);
        apb(1'b1, A_MBOX, 32'h1);
        rd_chk(A_MBOX, 32'hFF, 32'h0);
        for (int i = 0; i < 9; i++) begin
            i_rem.bcast(1'b0, 20'h1, 8'hA0 + 8'(i));
        end
        i_rem.bcast(1'b0, 20'h2, 8'h55);
        ipl_is(3'd2);
        for (int i = 0; i < 8; i++) begin
            rd_chk(A_BQ0, 32'h1FFF, ((8 - i) << 9) | 32'h1A0 | i);
        end
        rd_chk(A_BQ0, 32'h1F00, 32'h0);
        i_rem.bcast(1'b1, 20'h1, 8'h3C);
        i_rem.bcast(1'b1, 20'h1, 8'hC3);
        ipl_is(3'd6);
        rd_chk(A_BS1, 32'h1FF, 32'h13C);
        rd_chk(A_BS1, 32'h100, 32'h0);
        chk_flag(irq, 1'b1);
        rd_chk(A_EVT, 32'hF, 32'hF);
        repeat (3) @(posedge mclk);
        chk_flag(irq, 1'b0);
        rd_chk(A_EVT, 32'hF, 32'h0);
        tally_and_finish();
    end
endmodule : tb_multiprocessor_interrupt_hub
bind mih_top mih_props u_props (.mclk, .reset_n, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pready, .pslverr, .cpu_iack, .iack_done,
    .iack_ans, .mbx_stb, .mbx_idx, .mbx_ack, .mbx_old);
